// file: common/swlc_pkg.sv
/*
  Package for the swing and length/count block: register map, field widths,
  reset values, function codes and timing constants.
  Assumes a 100 MHz clock and 32-bit classic Wishbone register access.
*/
`default_nettype none
package swlc_pkg;

  localparam int CLK_HZ = 100_000_000;
  // Swing period unit is 0.1 s; a tick every 0.1 ms gives 1000 ticks per unit
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICKS_PER_PERIOD_UNIT = 1000;

  localparam logic [7:0] OFF_BASE_SEL = 8'h00;
  localparam logic [7:0] OFF_AMP_PCT = 8'h04;
  localparam logic [7:0] OFF_JUMP_PCT = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_RISE_COEF = 8'h10;
  localparam logic [7:0] OFF_TGT_LEN = 8'h14;
  localparam logic [7:0] OFF_MEAS_LEN = 8'h18;
  localparam logic [7:0] OFF_PPM = 8'h1C;
  localparam logic [7:0] OFF_FINAL_CNT = 8'h20;
  localparam logic [7:0] OFF_MID_CNT = 8'h24;
  localparam logic [7:0] OFF_SET_FREQ = 8'h28;
  localparam logic [7:0] OFF_MAX_FREQ = 8'h2C;
  localparam logic [7:0] OFF_UPPER_FREQ = 8'h30;
  localparam logic [7:0] OFF_LOWER_FREQ = 8'h34;
  localparam logic [7:0] OFF_IN_FUNC = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;
  localparam logic [7:0] OFF_COUNT = 8'h40;
  localparam logic [7:0] OFF_OUT_FREQ = 8'h44;

  // Percent fields in 0.1 %, coefficient in 0.01 %
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  localparam logic [15:0] PCT_HALF = 16'h01F4;
  localparam logic [15:0] COEF_FULL = 16'h2710;
  localparam logic [15:0] RST_PERIOD = 16'h0064;
  localparam logic [15:0] RST_COEF = 16'h1388;
  localparam logic [15:0] RST_TGT_LEN = 16'h03E8;
  localparam logic [15:0] RST_PPM = 16'h03E8;
  localparam logic [15:0] RST_CNT = 16'h03E8;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1388;

  localparam logic [4:0] FN_COUNT_IN = 5'd25;
  localparam logic [4:0] FN_LEN_IN = 5'd27;
  localparam logic [4:0] FN_LEN_RST = 5'd28;
  localparam int N_INPUTS = 4;
  localparam int FAST_IDX = 2;

  localparam int FLAG_CNT_FINAL = 0;
  localparam int FLAG_CNT_MID = 1;
  localparam int FLAG_LEN = 2;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } swlc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } swlc_wb_rsp_t;

endpackage
`default_nettype wire

// file: logic/swlc_sync.sv
/*
  Three-stage synchroniser bank for the digital input pins.
  A change counts once stages two and three agree; stage one feeds only stage two.
*/
`timescale 1ns/1ps
`default_nettype none
module swlc_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] rise
);
  import swlc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } swlc_sync_state_t;

  swlc_sync_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.rise = '0;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
        st_d.rise[i] = st_q.s3[i] & ~st_q.lvl[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.lvl;
  assign rise = st_q.rise;
endmodule
`default_nettype wire

// file: logic/swlc_top.sv
/*
  Swing frequency generator with jump step, fixed-length meter and pulse counter,
  all reached over a classic Wishbone slave.
  Assumes one 100 MHz clock, synchronous reset, and pulse pins from outside the domain.
*/
// Functional notes
// - Zero amplitude setting gives zero swing; output is the base frequency clamped between upper and lower limits.
// - Base selector 0 uses set frequency, 1 uses maximum output frequency.
// - Swing amplitude is base frequency times amplitude percent, up to full scale.
// - Jump step is swing amplitude times jump percent, at most half scale.
// - Swung output frequency is clamped between upper and lower limits.
// - One swing cycle lasts the period, 0.1 s to 3000.0 s, default 10.0 s.
// - Rise time is period times coefficient, fall time the remainder; default 50 %.
// - Measured length is length pulse count divided by pulses per metre.
// - Length reached flag sets once measured length exceeds target length.
// - An input with length reset function clears the measured length.
// - Length pulses come only from inputs assigned function 27; fast input serves high rates, but FAST_IDX gets the same three-stage sync as every input.
// - Count pulses come from inputs assigned function 25; fast input serves high rates, but FAST_IDX gets the same three-stage sync as every input.
// - Final flag sets and counting stops when count reaches final target.
// - Intermediate flag sets at intermediate target; counting continues to final.
`timescale 1ns/1ps
`default_nettype none
module swlc_top #(
  parameter int N_IN = swlc_pkg::N_INPUTS,
  parameter int TICK_DIV = swlc_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire swlc_pkg::swlc_wb_req_t WB_REQ,
  output swlc_pkg::swlc_wb_rsp_t WB_RSP,
  input wire logic [N_IN-1:0] DIN,
  output logic [15:0] OUT_FREQ,
  output logic [2:0] FLAG_OUT
);
  import swlc_pkg::*;

  typedef enum logic [0:0] {
    SW_RISE = 1'b0,
    SW_FALL = 1'b1
  } swlc_phase_t;

  typedef struct packed {
    logic [15:0] base_sel;
    logic [15:0] amp_pct;
    logic [15:0] jump_pct;
    logic [15:0] period;
    logic [15:0] rise_coef;
    logic [15:0] tgt_len;
    logic [15:0] ppm;
    logic [15:0] final_cnt;
    logic [15:0] mid_cnt;
    logic [15:0] set_freq;
    logic [15:0] max_freq;
    logic [15:0] upper_freq;
    logic [15:0] lower_freq;
    logic [N_IN*5-1:0] in_func;
    logic [31:0] len_pulses;
    logic [15:0] meas_len;
    logic [15:0] count;
    logic [2:0] flags;
    swlc_phase_t phase;
    logic [31:0] ph_ticks;
    logic [31:0] tick_div;
    logic [15:0] offset;
    logic [15:0] out_freq;
    logic ack;
    logic [31:0] rdat;
  } swlc_state_t;

  swlc_state_t st_q, st_d;
  logic [N_IN-1:0] pin_lvl;
  logic [N_IN-1:0] pin_rise;

  swlc_sync #(
    .W(N_IN)
  ) u_sync (
    .clk(CLK),
    .srst(SRST),
    .din(DIN),
    .dout(pin_lvl),
    .rise(pin_rise)
  );

  // Input function lookup, used for count, length and reset selection
  function automatic logic [N_IN-1:0] fn_match(input logic [N_IN*5-1:0] f,
                                               input logic [4:0] code);
    logic [N_IN-1:0] m;
    m = '0;
    for (int i = 0; i < N_IN; i++) begin
      m[i] = (f[i*5 +: 5] == code);
    end
    return m;
  endfunction

  // Scale a 16-bit value by a fraction num/den
  function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] num,
                                        input logic [15:0] den);
    logic [31:0] p;
    p = 32'(v) * 32'(num);
    return 16'(p / 32'(den));
  endfunction

  function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  logic [15:0] base_f, amp_f, jump_f, lim_amp, lim_jump;
  logic [31:0] period_ticks, rise_ticks, fall_ticks;
  logic [N_IN-1:0] cnt_in, len_in, len_rst;
  logic [31:0] freq_raw;
  logic [31:0] len_calc;
  logic wb_hit;

  always_comb begin
    base_f = st_q.base_sel[0] ? st_q.max_freq : st_q.set_freq;
    lim_amp = (st_q.amp_pct > PCT_FULL) ? PCT_FULL : st_q.amp_pct;
    lim_jump = (st_q.jump_pct > PCT_HALF) ? PCT_HALF : st_q.jump_pct;
    amp_f = scale(base_f, lim_amp, PCT_FULL);
    jump_f = scale(amp_f, lim_jump, PCT_FULL);
    period_ticks = 32'(st_q.period) * 32'(TICKS_PER_PERIOD_UNIT);
    rise_ticks = 32'((64'(period_ticks) * 64'(st_q.rise_coef)) / 64'(COEF_FULL));
    fall_ticks = period_ticks - rise_ticks;
    cnt_in = fn_match(st_q.in_func, FN_COUNT_IN) & pin_rise;
    len_in = fn_match(st_q.in_func, FN_LEN_IN) & pin_rise;
    len_rst = fn_match(st_q.in_func, FN_LEN_RST) & pin_lvl;
    wb_hit = WB_REQ.cyc & WB_REQ.stb & ~st_q.ack;
  end

  always_comb begin
    st_d = st_q;
    st_d.ack = wb_hit;
    st_d.rdat = '0;

    // Swing triangle: offset ramps 0..2*amp over rise, back over fall
    st_d.tick_div = (st_q.tick_div >= 32'(TICK_DIV - 1)) ? '0 : st_q.tick_div + 32'd1;
    if (amp_f == '0) begin
      st_d.offset = '0;
      st_d.phase = SW_RISE;
      st_d.ph_ticks = '0;
    end else if (st_q.tick_div == '0) begin
      unique case (st_q.phase)
        SW_RISE: begin
          if (st_q.ph_ticks + 32'd1 >= rise_ticks) begin
            st_d.phase = SW_FALL;
            st_d.ph_ticks = '0;
          end else begin
            st_d.ph_ticks = st_q.ph_ticks + 32'd1;
          end
        end
        SW_FALL: begin
          if (st_q.ph_ticks + 32'd1 >= fall_ticks) begin
            st_d.phase = SW_RISE;
            st_d.ph_ticks = '0;
          end else begin
            st_d.ph_ticks = st_q.ph_ticks + 32'd1;
          end
        end
      endcase
      // Triangle value in 0..2*amp, centred later; jump pushes away from the peak
      if (st_d.phase == SW_RISE) begin
        st_d.offset = (rise_ticks == '0) ? 16'(2 * amp_f) :
          16'((64'(st_d.ph_ticks) * 64'(2 * 32'(amp_f))) / 64'(rise_ticks));
      end else begin
        st_d.offset = (fall_ticks == '0) ? '0 :
          16'(2 * 32'(amp_f) - (64'(st_d.ph_ticks) * 64'(2 * 32'(amp_f))) / 64'(fall_ticks));
      end
    end

    // Jump: rise runs high by jump after its first tick, fall starts low by jump
    if (amp_f == '0) begin
      freq_raw = 32'(base_f);
    end else if (st_q.phase == SW_RISE) begin
      freq_raw = 32'(base_f) + 32'(st_q.offset) + 32'(jump_f) - 32'(amp_f)
                 - 32'(jump_f) + ((st_q.ph_ticks == '0) ? 32'd0 : 32'(jump_f));
    end else begin
      freq_raw = 32'(base_f) + 32'(st_q.offset) - 32'(amp_f)
                 - ((st_q.ph_ticks == '0) ? 32'(jump_f) : 32'd0);
    end
    if (freq_raw[31] || freq_raw < 32'(st_q.lower_freq)) begin
      st_d.out_freq = st_q.lower_freq;
    end else if (freq_raw > 32'(st_q.upper_freq)) begin
      st_d.out_freq = st_q.upper_freq;
    end else begin
      st_d.out_freq = freq_raw[15:0];
    end

    // Pulse counter
    if (!st_q.flags[FLAG_CNT_FINAL] && (|cnt_in)) begin
      st_d.count = st_q.count + 16'd1;
    end
    if (st_d.count >= st_q.final_cnt) begin
      st_d.flags[FLAG_CNT_FINAL] = 1'b1;
    end
    if (st_d.count >= st_q.mid_cnt) begin
      st_d.flags[FLAG_CNT_MID] = 1'b1;
    end

    // Length meter; pulses_per_metre is in 0.1 units
    if (|len_rst) begin
      st_d.len_pulses = '0;
    end else if (|len_in) begin
      st_d.len_pulses = st_q.len_pulses + 32'd1;
    end
    len_calc = (st_q.ppm == '0) ? '0 : (st_q.len_pulses * 32'd10) / 32'(st_q.ppm);
    st_d.meas_len = (len_calc > 32'h0000FFFF) ? 16'hFFFF : len_calc[15:0];
    st_d.flags[FLAG_LEN] = (st_q.meas_len > st_q.tgt_len);

    if (wb_hit && WB_REQ.we) begin
      unique case (WB_REQ.adr)
        OFF_BASE_SEL: st_d.base_sel = wmask(st_q.base_sel, WB_REQ.dat, WB_REQ.sel);
        OFF_AMP_PCT: st_d.amp_pct = wmask(st_q.amp_pct, WB_REQ.dat, WB_REQ.sel);
        OFF_JUMP_PCT: st_d.jump_pct = wmask(st_q.jump_pct, WB_REQ.dat, WB_REQ.sel);
        OFF_PERIOD: st_d.period = wmask(st_q.period, WB_REQ.dat, WB_REQ.sel);
        OFF_RISE_COEF: st_d.rise_coef = wmask(st_q.rise_coef, WB_REQ.dat, WB_REQ.sel);
        OFF_TGT_LEN: st_d.tgt_len = wmask(st_q.tgt_len, WB_REQ.dat, WB_REQ.sel);
        OFF_MEAS_LEN: st_d.len_pulses = '0;
        OFF_PPM: st_d.ppm = wmask(st_q.ppm, WB_REQ.dat, WB_REQ.sel);
        OFF_FINAL_CNT: st_d.final_cnt = wmask(st_q.final_cnt, WB_REQ.dat, WB_REQ.sel);
        OFF_MID_CNT: st_d.mid_cnt = wmask(st_q.mid_cnt, WB_REQ.dat, WB_REQ.sel);
        OFF_SET_FREQ: st_d.set_freq = wmask(st_q.set_freq, WB_REQ.dat, WB_REQ.sel);
        OFF_MAX_FREQ: st_d.max_freq = wmask(st_q.max_freq, WB_REQ.dat, WB_REQ.sel);
        OFF_UPPER_FREQ: st_d.upper_freq = wmask(st_q.upper_freq, WB_REQ.dat, WB_REQ.sel);
        OFF_LOWER_FREQ: st_d.lower_freq = wmask(st_q.lower_freq, WB_REQ.dat, WB_REQ.sel);
        OFF_IN_FUNC: begin
          for (int b = 0; b < 4; b++) begin
            if (WB_REQ.sel[b] && (b * 8 < N_IN * 5)) begin
              for (int k = 0; k < 8; k++) begin
                if (b * 8 + k < N_IN * 5) begin
                  st_d.in_func[b * 8 + k] = WB_REQ.dat[b * 8 + k];
                end
              end
            end
          end
        end
        OFF_COUNT: begin
          // Restarting the count also rearms both count flags
          st_d.count = '0;
          st_d.flags[FLAG_CNT_FINAL] = 1'b0;
          st_d.flags[FLAG_CNT_MID] = 1'b0;
        end
        default: ;
      endcase
    end else if (wb_hit) begin
      unique case (WB_REQ.adr)
        OFF_BASE_SEL: st_d.rdat = {16'h0000, st_q.base_sel};
        OFF_AMP_PCT: st_d.rdat = {16'h0000, lim_amp};
        OFF_JUMP_PCT: st_d.rdat = {16'h0000, lim_jump};
        OFF_PERIOD: st_d.rdat = {16'h0000, st_q.period};
        OFF_RISE_COEF: st_d.rdat = {16'h0000, st_q.rise_coef};
        OFF_TGT_LEN: st_d.rdat = {16'h0000, st_q.tgt_len};
        OFF_MEAS_LEN: st_d.rdat = {16'h0000, st_q.meas_len};
        OFF_PPM: st_d.rdat = {16'h0000, st_q.ppm};
        OFF_FINAL_CNT: st_d.rdat = {16'h0000, st_q.final_cnt};
        OFF_MID_CNT: st_d.rdat = {16'h0000, st_q.mid_cnt};
        OFF_SET_FREQ: st_d.rdat = {16'h0000, st_q.set_freq};
        OFF_MAX_FREQ: st_d.rdat = {16'h0000, st_q.max_freq};
        OFF_UPPER_FREQ: st_d.rdat = {16'h0000, st_q.upper_freq};
        OFF_LOWER_FREQ: st_d.rdat = {16'h0000, st_q.lower_freq};
        OFF_IN_FUNC: st_d.rdat = 32'(st_q.in_func);
        OFF_STATUS: st_d.rdat = {28'h0000000, 1'(st_q.phase), st_q.flags};
        OFF_COUNT: st_d.rdat = {16'h0000, st_q.count};
        OFF_OUT_FREQ: st_d.rdat = {16'h0000, st_q.out_freq};
        default: st_d.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= '0;
      st_q.period <= RST_PERIOD;
      st_q.rise_coef <= RST_COEF;
      st_q.tgt_len <= RST_TGT_LEN;
      st_q.ppm <= RST_PPM;
      st_q.final_cnt <= RST_CNT;
      st_q.mid_cnt <= RST_CNT;
      st_q.max_freq <= RST_MAX_FREQ;
      st_q.upper_freq <= RST_MAX_FREQ;
    end else begin
      st_q <= st_d;
    end
  end

  assign WB_RSP.ack = st_q.ack;
  assign WB_RSP.dat = st_q.rdat;
  assign OUT_FREQ = st_q.out_freq;
  assign FLAG_OUT = st_q.flags;
endmodule
`default_nettype wire

// file: verification/swlc_top_sva.sv
/*
  Port checker for swlc_top: bus handshake, reset and flag behaviour.
  Assumes a master that holds its request until ack and drops it after.
*/
`timescale 1ns/1ps
`default_nettype none
module swlc_top_chk #(
  parameter int N_IN = 4
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire swlc_pkg::swlc_wb_req_t WB_REQ,
  input wire swlc_pkg::swlc_wb_rsp_t WB_RSP,
  input wire logic [N_IN-1:0] DIN,
  input wire logic [15:0] OUT_FREQ,
  input wire logic [2:0] FLAG_OUT
);
  import swlc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic req;
  logic wr_cnt;
  logic [7:0] act_q;
  assign req = WB_REQ.cyc && WB_REQ.stb;
  assign wr_cnt = req && WB_REQ.we && WB_REQ.adr == OFF_COUNT;
  // Recent pin or write activity: flags may only move after one of these
  always_ff @(posedge CLK) act_q <= {act_q[6:0], (|DIN) || (req && WB_REQ.we)};
  sequence s_take;
    req && !WB_RSP.ack;
  endsequence
  sequence s_answer;
    WB_RSP.ack ##1 !WB_RSP.ack;
  endsequence
  a_ack_next: assert property (s_take |=> s_answer)
    else $error("Request not answered in one cycle");
  a_ack_cause: assert property (WB_RSP.ack |-> $past(req))
    else $error("Ack without a request");
  a_dat_idle: assert property (!WB_RSP.ack |-> WB_RSP.dat == 32'h0)
    else $error("Read data not zero outside ack");
  a_reset_clear: assert property (disable iff (1'b0) SRST |=>
    OUT_FREQ == 16'h0 && FLAG_OUT == 3'h0 && !WB_RSP.ack) else $error("Reset left outputs set");
  a_flags_sticky: assert property (act_q == 8'h0 && !(req && WB_REQ.we) |=>
    (FLAG_OUT[1:0] & $past(FLAG_OUT[1:0])) == $past(FLAG_OUT[1:0]))
    else $error("Count flag dropped without a count write");
  a_final_mid: assert property (FLAG_OUT[0] |-> FLAG_OUT[1])
    else $error("Final count flag without intermediate flag");
  a_count_clear: assert property (wr_cnt && WB_RSP.ack |-> ##[1:3] FLAG_OUT[1:0] == 2'h0)
    else $error("Count write did not clear count flags");
  a_len_drop: assert property ($fell(FLAG_OUT[2]) |-> act_q != 8'h0)
    else $error("Length flag dropped with no cause");
endmodule
bind swlc_top swlc_top_chk #(.N_IN(N_IN)) u_chk (.CLK(CLK), .SRST(SRST), .WB_REQ(WB_REQ),
  .WB_RSP(WB_RSP), .DIN(DIN), .OUT_FREQ(OUT_FREQ), .FLAG_OUT(FLAG_OUT));
`default_nettype wire

// file: verification/swlc_pulse_src.sv
/*
  Model of the pulse sensors wired to the digital input pins.
  Assumes inputs idle low; the bench calls pulse() to emit clean pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module swlc_pulse_src #(
  parameter int N = 4
) (
  input wire logic clk,
  output logic [N-1:0] din
);
  initial din = '0;
  // Six clocks each way so the three-stage sync sees every edge once
  task automatic pulse(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      din[idx] <= 1'b1;
      repeat (6) @(posedge clk);
      din[idx] <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: verification/swlc_top_tb.sv
/*
  Self-checking bench for swlc_top: registers, counter, length meter, swing.
  Assumes the pulse model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module swlc_top_tb;
  import swlc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  swlc_wb_req_t req = '0;
  swlc_wb_rsp_t rsp;
  logic [3:0] din;
  logic [15:0] out_freq;
  logic [2:0] flags;
  int n_fail = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  // Short tick so one 0.1 s period unit is 2000 clocks
  swlc_top #(.N_IN(4), .TICK_DIV(2)) dut (.CLK(clk), .SRST(srst), .WB_REQ(req),
    .WB_RSP(rsp), .DIN(din), .OUT_FREQ(out_freq), .FLAG_OUT(flags));
  swlc_pulse_src #(.N(4)) src (.clk(clk), .din(din));
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    int i;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: wd};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rsp.ack !== 1'b1 && i < 20);
    rd = rsp.dat;
    req <= '0;
    if (i >= 20) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    wb(1'b0, a, 32'h0, d);
    `CHK(d, e)
  endtask
  task automatic t_reset_values();
    chk_rd(OFF_PERIOD, {16'h0, RST_PERIOD});
    chk_rd(OFF_RISE_COEF, {16'h0, RST_COEF});
    chk_rd(OFF_TGT_LEN, {16'h0, RST_TGT_LEN});
    chk_rd(OFF_PPM, {16'h0, RST_PPM});
    chk_rd(OFF_FINAL_CNT, {16'h0, RST_CNT});
    chk_rd(OFF_MID_CNT, {16'h0, RST_CNT});
    chk_rd(OFF_AMP_PCT, 32'h0);
    chk_rd(OFF_MAX_FREQ, {16'h0, RST_MAX_FREQ});
    chk_rd(OFF_UPPER_FREQ, {16'h0, RST_MAX_FREQ});
    chk_rd(8'hFC, 32'h0);
    wr(OFF_AMP_PCT, 32'hFFFF);
    chk_rd(OFF_AMP_PCT, {16'h0, PCT_FULL});
    wr(OFF_JUMP_PCT, 32'h0FFF);
    chk_rd(OFF_JUMP_PCT, {16'h0, PCT_HALF});
    wr(OFF_AMP_PCT, 32'h0);
    wr(OFF_JUMP_PCT, 32'h0);
  endtask
  task automatic t_count();
    wr(OFF_IN_FUNC, 32'h000E0379);
    wr(OFF_MID_CNT, 32'h2);
    wr(OFF_FINAL_CNT, 32'h3);
    src.pulse(0, 2);
    `CHK(flags, 3'b010)
    src.pulse(0, 2);
    `CHK(flags, 3'b011)
    chk_rd(OFF_STATUS, 32'h3);
    chk_rd(OFF_COUNT, 32'h3);
    chk_rd(OFF_MEAS_LEN, 32'h0);
    wr(OFF_COUNT, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(flags, 3'b000)
  endtask
  task automatic t_length();
    wr(OFF_PPM, 32'hA);
    wr(OFF_TGT_LEN, 32'h2);
    src.pulse(1, 2);
    chk_rd(OFF_MEAS_LEN, 32'h2);
    `CHK(flags[2], 1'b0)
    src.pulse(1, 1);
    `CHK(flags[2], 1'b1)
    src.pulse(3, 1);
    chk_rd(OFF_MEAS_LEN, 32'h0);
    `CHK(flags[2], 1'b0)
  endtask
  // A reset in mid-run must drop the count and the input assignment
  task automatic t_reset_mid();
    src.pulse(0, 1);
    chk_rd(OFF_COUNT, 32'h1);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk_rd(OFF_COUNT, 32'h0);
    chk_rd(OFF_IN_FUNC, 32'h0);
  endtask
  task automatic span(input logic [15:0] hi, input logic [15:0] lo);
    logic [15:0] mx;
    logic [15:0] mn;
    mx = 16'h0;
    mn = 16'hFFFF;
    repeat (2200) @(posedge clk);
    repeat (4400) begin
      @(posedge clk);
      if (out_freq > mx) mx = out_freq;
      if (out_freq < mn) mn = out_freq;
    end
    `CHK(mx, hi)
    `CHK(mn, lo)
  endtask
  task automatic t_swing();
    wr(OFF_PERIOD, 32'h1);
    wr(OFF_SET_FREQ, 32'h3E8);
    repeat (20) @(posedge clk);
    `CHK(out_freq, 16'h03E8)
    chk_rd(OFF_OUT_FREQ, 32'h3E8);
    wr(OFF_AMP_PCT, 32'h64);
    span(16'h044C, 16'h0384);
    wr(OFF_UPPER_FREQ, 32'h41A);
    wr(OFF_LOWER_FREQ, 32'h3C0);
    span(16'h041A, 16'h03C0);
    wr(OFF_UPPER_FREQ, 32'hFFFF);
    wr(OFF_LOWER_FREQ, 32'h0);
    wr(OFF_BASE_SEL, 32'h1);
    span(16'h157C, 16'h1194);
  endtask
  // Base 5000, swing 10 % gives 500; a 10 % jump is 50, seen as a one-cycle fall at the top
  task automatic t_jump();
    logic [15:0] pv;
    logic [15:0] dn;
    dn = 16'h0;
    wr(OFF_JUMP_PCT, 32'h64);
    @(posedge clk);
    pv = out_freq;
    repeat (4400) begin
      @(posedge clk);
      if (out_freq < pv && (pv - out_freq) > dn) dn = pv - out_freq;
      pv = out_freq;
    end
    `CHK(dn >= 16'd50, 1'b1)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset_values();
    t_count();
    t_length();
    t_reset_mid();
    t_swing();
    t_jump();
    end_of_test();
  end
endmodule
`default_nettype wire
